//--- common/pwm_defines.svh
// Offsets, field positions, reset values and sizes of the PWM channel block.
// Assumes inclusion by bare name from the design files.
`ifndef PWM_DEFINES_SVH
`define PWM_DEFINES_SVH

`define NUM_CH 2
`define CNT_W 16
`define DT_W 8
`define MODE_W 9
`define CNT_ONE 16'h0001

`define OFS_MODE 5'h00
`define OFS_PERIOD 5'h04
`define OFS_UPDATE 5'h08
`define OFS_DEADTIME 5'h0C
`define OFS_ISR 8'h80
`define OFS_IMR 8'h84
`define OFS_ENA 8'h88
`define OFS_STAT 8'h8C

`define UPD_POL_BIT 16
`define DT_LOW_LSB 8
`define STAT_POL_LSB 8
`define STAT_OC_LSB 16

`define PERIOD_RST 16'h00FF
`define DUTY_RST 16'h0000
`define DT_RST 16'h0000

`endif

//--- common/pwm_pkg.sv
// Types shared by the PWM channel block.
// Assumes nothing of its surroundings.
package pwm_pkg;

  typedef struct packed {
    logic push_pull_enable;
    logic low_side_invert;
    logic high_side_invert;
    logic deadtime_enable;
    logic timer_trigger_select;
    logic disabled_level_invert;
    logic update_select;
    logic event_select;
    logic centre_align;
  } mode_t;

  typedef struct packed {
    logic end_evt;
    logic half_evt;
    logic compare_output;
  } cnt_evt_t;

  typedef enum logic {DIR_UP, DIR_DOWN} dir_t;

endpackage

//--- verilog/pwm_counter.sv
// Period counter and comparator of one PWM channel.
// Assumes period, duty and polarity from same-clock registers.
`timescale 1ns/1ps
`include "pwm_defines.svh"

module pwm_counter import pwm_pkg::*; (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Settings
  input wire logic en,
  input wire logic centre,
  input wire logic [`CNT_W-1:0] period,
  input wire logic [`CNT_W-1:0] duty,
  input wire logic pol,
  // Events and comparator
  output cnt_evt_t evt
);

  logic [`CNT_W-1:0] cnt_r;
  dir_t dir_r;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_r <= '0;
      dir_r <= DIR_UP;
    end else if (!en) begin
      cnt_r <= '0;
      dir_r <= DIR_UP;
    end else begin
      case (dir_r)
        DIR_UP: begin
          if (cnt_r >= period) begin
            // Centre mode turns round at the top instead of wrapping
            if (centre && cnt_r != '0) begin
              dir_r <= DIR_DOWN;
              cnt_r <= cnt_r - `CNT_ONE;
            end else begin
              cnt_r <= '0;
            end
          end else begin
            cnt_r <= cnt_r + `CNT_ONE;
          end
        end
        DIR_DOWN: begin
          if (cnt_r == '0) begin
            dir_r <= DIR_UP;
            cnt_r <= `CNT_ONE;
          end else begin
            cnt_r <= cnt_r - `CNT_ONE;
          end
        end
        default: dir_r <= DIR_UP;
      endcase
    end
  end

  assign evt.end_evt = en && (centre ? (dir_r == DIR_DOWN && cnt_r == '0) : (cnt_r >= period));
  assign evt.half_evt = en && centre && dir_r == DIR_UP && cnt_r >= period && cnt_r != '0;
  assign evt.compare_output = (cnt_r < duty) ? pol : !pol;

  left_wrap_a: assert property (@(posedge clk) disable iff (rst)
    (en && !centre && evt.end_evt) |=> (cnt_r == '0 || !en))
    else $error("left aligned period end did not wrap the counter");

endmodule

//--- verilog/pwm_deadtime.sv
// Dead-time generator of one PWM channel: delays the rising edge of each side.
// Assumes the comparator level comes from the same clock.
`timescale 1ns/1ps
`include "pwm_defines.svh"

module pwm_deadtime (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Settings
  input wire logic en,
  input wire logic [`DT_W-1:0] dt_high,
  input wire logic [`DT_W-1:0] dt_low,
  // Comparator in, side outputs out
  input wire logic oc,
  output logic high,
  output logic low
);

  logic oc_d_r;
  logic [`DT_W-1:0] cnt_r;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      oc_d_r <= 1'b0;
      cnt_r <= '0;
    end else begin
      oc_d_r <= oc;
      if (oc != oc_d_r) begin
        cnt_r <= oc ? dt_high : dt_low;
      end else if (cnt_r != '0) begin
        cnt_r <= cnt_r - 8'h01;
      end
    end
  end

  assign high = en ? (oc && oc_d_r && cnt_r == '0) : oc;
  assign low = en ? (!oc && !oc_d_r && cnt_r == '0) : !oc;

  no_overlap_a: assert property (@(posedge clk) disable iff (rst)
    en |-> !(high && low))
    else $error("both sides active while dead time is on");

endmodule

//--- verilog/pwm_mode_top.sv
// PWM channels with per-channel mode options behind an APB slave.
// Assumes a 200 MHz CORE_CLK, APB master on the same clock, outputs to switch drivers.
`timescale 1ns/1ps
`include "pwm_defines.svh"

// Functional notes
// - Left alignment: event only at period end; centre with select 1 adds half period.
// - Left alignment: buffered duty and polarity load at period end.
// - Centre alignment, update select 0: load at next full period end.
// - Centre alignment, update select 1: load at next half period end.
// - Disabled channel outputs polarity level, inverted when invert bit set.
// - Timer trigger is comparator output when select 0, counter event when 1.
// - Dead-time generator works only while enabled, bypassed otherwise.
// - High-side invert bit inverts the high-side output.
// - Low-side invert bit inverts the low-side output.
module pwm_mode_top import pwm_pkg::*; (
  // Clock and reset
  input wire logic CORE_CLK,
  input wire logic RESET,
  // APB slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // Channel outputs
  output logic [`NUM_CH-1:0] PWM_HIGH,
  output logic [`NUM_CH-1:0] PWM_LOW,
  output logic [`NUM_CH-1:0] TRIG_OUT,
  // Interrupt
  output logic IRQ
);

  mode_t mode_r [`NUM_CH];
  logic [`CNT_W-1:0] period_r [`NUM_CH];
  logic [15:0] dt_r [`NUM_CH];
  logic [`CNT_W-1:0] buf_duty_r [`NUM_CH];
  logic [`CNT_W-1:0] act_duty_r [`NUM_CH];
  logic [`NUM_CH-1:0] buf_pol_r;
  logic [`NUM_CH-1:0] act_pol_r;
  logic [`NUM_CH-1:0] pend_r;
  logic [`NUM_CH-1:0] phase_r;
  logic [`NUM_CH-1:0] ena_r;
  logic [`NUM_CH-1:0] status_r;
  logic [`NUM_CH-1:0] status_nxt;
  logic [`NUM_CH-1:0] mask_r;
  logic [31:0] rd_nxt;
  logic [31:0] rd_r;
  logic irq_r;
  logic [`NUM_CH-1:0] hi_r;
  logic [`NUM_CH-1:0] lo_r;
  logic [`NUM_CH-1:0] trig_r;

  cnt_evt_t evt [`NUM_CH];
  logic [`NUM_CH-1:0] ch_evt;
  logic [`NUM_CH-1:0] upd_pt;
  logic [`NUM_CH-1:0] upd_wr;
  logic [`NUM_CH-1:0] oc;
  logic [`NUM_CH-1:0] dt_h;
  logic [`NUM_CH-1:0] dt_l;
  logic [`NUM_CH-1:0] hi_f;
  logic [`NUM_CH-1:0] lo_f;

  logic acc;
  logic wr;
  logic ok;

  function automatic logic addr_ok(input logic [7:0] a);
    if (a[7]) begin
      addr_ok = (a[6:4] == 3'h0) && (a[1:0] == 2'h0);
    end else begin
      addr_ok = (32'(a[6:5]) < `NUM_CH) && !a[4] && (a[1:0] == 2'h0);
    end
  endfunction

  function automatic logic hit(input logic [7:0] a, input int c, input logic [4:0] s);
    hit = !a[7] && (32'(a[6:5]) == c) && (a[4:0] == s);
  endfunction

  // Zero wait states; read data is captured in the setup cycle
  assign acc = PSEL && PENABLE;
  assign ok = addr_ok(PADDR);
  assign wr = acc && PWRITE && ok;
  assign PREADY = acc;
  assign PSLVERR = acc && !ok;
  assign PRDATA = rd_r;
  assign IRQ = irq_r;
  assign PWM_HIGH = hi_r;
  assign PWM_LOW = lo_r;
  assign TRIG_OUT = trig_r;

  always_comb begin
    rd_nxt = 32'h00000000;
    case (PADDR)
      `OFS_ISR: rd_nxt[`NUM_CH-1:0] = status_r;
      `OFS_IMR: rd_nxt[`NUM_CH-1:0] = mask_r;
      `OFS_ENA: rd_nxt[`NUM_CH-1:0] = ena_r;
      `OFS_STAT: begin
        rd_nxt[`NUM_CH-1:0] = pend_r;
        rd_nxt[`STAT_POL_LSB +: `NUM_CH] = act_pol_r;
        rd_nxt[`STAT_OC_LSB +: `NUM_CH] = oc;
      end
      default: begin
        for (int c = 0; c < `NUM_CH; c++) begin
          if (hit(PADDR, c, `OFS_MODE)) rd_nxt[`MODE_W-1:0] = mode_r[c];
          if (hit(PADDR, c, `OFS_PERIOD)) rd_nxt[`CNT_W-1:0] = period_r[c];
          if (hit(PADDR, c, `OFS_UPDATE)) begin
            rd_nxt[`CNT_W-1:0] = buf_duty_r[c];
            rd_nxt[`UPD_POL_BIT] = buf_pol_r[c];
          end
          if (hit(PADDR, c, `OFS_DEADTIME)) rd_nxt[15:0] = dt_r[c];
        end
      end
    endcase
  end

  always_ff @(posedge CORE_CLK or posedge RESET) begin
    if (RESET) begin
      rd_r <= 32'h00000000;
    end else if (PSEL && !PENABLE) begin
      rd_r <= rd_nxt;
    end
  end

  always_ff @(posedge CORE_CLK or posedge RESET) begin
    if (RESET) begin
      for (int c = 0; c < `NUM_CH; c++) begin
        mode_r[c] <= '0;
        period_r[c] <= `PERIOD_RST;
        dt_r[c] <= `DT_RST;
      end
    end else begin
      for (int c = 0; c < `NUM_CH; c++) begin
        if (wr && hit(PADDR, c, `OFS_MODE)) mode_r[c] <= mode_t'(PWDATA[`MODE_W-1:0]);
        if (wr && hit(PADDR, c, `OFS_PERIOD)) period_r[c] <= PWDATA[`CNT_W-1:0];
        if (wr && hit(PADDR, c, `OFS_DEADTIME)) dt_r[c] <= PWDATA[15:0];
      end
    end
  end

  always_ff @(posedge CORE_CLK or posedge RESET) begin
    if (RESET) begin
      ena_r <= '0;
      mask_r <= '0;
    end else begin
      if (wr && PADDR == `OFS_ENA) ena_r <= PWDATA[`NUM_CH-1:0];
      if (wr && PADDR == `OFS_IMR) mask_r <= PWDATA[`NUM_CH-1:0];
    end
  end

  // Buffered duty and polarity; a write in the load cycle waits for the next point
  always_ff @(posedge CORE_CLK or posedge RESET) begin
    if (RESET) begin
      pend_r <= '0;
      buf_pol_r <= '0;
      act_pol_r <= '0;
      for (int c = 0; c < `NUM_CH; c++) begin
        buf_duty_r[c] <= `DUTY_RST;
        act_duty_r[c] <= `DUTY_RST;
      end
    end else begin
      for (int c = 0; c < `NUM_CH; c++) begin
        if (upd_wr[c]) begin
          buf_duty_r[c] <= PWDATA[`CNT_W-1:0];
          buf_pol_r[c] <= PWDATA[`UPD_POL_BIT];
          pend_r[c] <= 1'b1;
        end else if (upd_pt[c] && pend_r[c]) begin
          act_duty_r[c] <= buf_duty_r[c];
          act_pol_r[c] <= buf_pol_r[c];
          pend_r[c] <= 1'b0;
        end
      end
    end
  end

  for (genvar c = 0; c < `NUM_CH; c++) begin : g_ch
    pwm_counter u_cnt (
      .clk(CORE_CLK),
      .rst(RESET),
      .en(ena_r[c]),
      .centre(mode_r[c].centre_align),
      .period(period_r[c]),
      .duty(act_duty_r[c]),
      .pol(act_pol_r[c]),
      .evt(evt[c])
    );

    assign upd_wr[c] = wr && hit(PADDR, c, `OFS_UPDATE);
    assign ch_evt[c] = evt[c].end_evt || (mode_r[c].event_select && evt[c].half_evt);
    assign upd_pt[c] = evt[c].end_evt || (mode_r[c].update_select && evt[c].half_evt);
    assign oc[c] = ena_r[c] ? evt[c].compare_output
                            : (act_pol_r[c] ^ mode_r[c].disabled_level_invert);

    pwm_deadtime u_dt (
      .clk(CORE_CLK),
      .rst(RESET),
      .en(mode_r[c].deadtime_enable),
      .dt_high(dt_r[c][`DT_W-1:0]),
      .dt_low(dt_r[c][`DT_LOW_LSB +: `DT_W]),
      .oc(oc[c]),
      .high(dt_h[c]),
      .low(dt_l[c])
    );

    assign hi_f[c] = mode_r[c].push_pull_enable ? (dt_h[c] && !phase_r[c]) : dt_h[c];
    assign lo_f[c] = mode_r[c].push_pull_enable ? (dt_h[c] && phase_r[c]) : dt_l[c];
  end

  always_ff @(posedge CORE_CLK or posedge RESET) begin
    if (RESET) begin
      phase_r <= '0;
    end else begin
      for (int c = 0; c < `NUM_CH; c++) begin
        if (!mode_r[c].push_pull_enable) phase_r[c] <= 1'b0;
        else if (evt[c].end_evt) phase_r[c] <= !phase_r[c];
      end
    end
  end

  // Outputs are registered so the switch drivers never see decode glitches
  always_ff @(posedge CORE_CLK or posedge RESET) begin
    if (RESET) begin
      hi_r <= '0;
      lo_r <= '0;
      trig_r <= '0;
    end else begin
      for (int c = 0; c < `NUM_CH; c++) begin
        hi_r[c] <= hi_f[c] ^ mode_r[c].high_side_invert;
        lo_r[c] <= lo_f[c] ^ mode_r[c].low_side_invert;
        trig_r[c] <= mode_r[c].timer_trigger_select ? ch_evt[c] : oc[c];
      end
    end
  end

  // Set wins over a write-one clear in the same cycle
  always_comb begin
    status_nxt = status_r;
    if (wr && PADDR == `OFS_ISR) status_nxt = status_r & ~PWDATA[`NUM_CH-1:0];
    status_nxt = status_nxt | ch_evt;
  end

  always_ff @(posedge CORE_CLK or posedge RESET) begin
    if (RESET) begin
      status_r <= '0;
      irq_r <= 1'b0;
    end else begin
      status_r <= status_nxt;
      irq_r <= |(status_nxt & mask_r);
    end
  end

  left_evt_a: assert property (@(posedge CORE_CLK) disable iff (RESET)
    (!mode_r[0].centre_align && ch_evt[0]) |-> evt[0].end_evt)
    else $error("left aligned event away from period end");

  half_evt_a: assert property (@(posedge CORE_CLK) disable iff (RESET)
    (mode_r[0].centre_align && mode_r[0].event_select && evt[0].half_evt) |=> status_r[0])
    else $error("half period event not flagged");

  left_upd_a: assert property (@(posedge CORE_CLK) disable iff (RESET)
    (!mode_r[0].centre_align && pend_r[0] && !upd_wr[0] && !evt[0].end_evt) |=> pend_r[0])
    else $error("left aligned update applied before period end");

  full_upd_a: assert property (@(posedge CORE_CLK) disable iff (RESET)
    (mode_r[0].centre_align && !mode_r[0].update_select && evt[0].half_evt && pend_r[0] && !upd_wr[0])
    |=> pend_r[0] && act_duty_r[0] == $past(act_duty_r[0]))
    else $error("full period update applied at half period");

  half_upd_a: assert property (@(posedge CORE_CLK) disable iff (RESET)
    (mode_r[0].centre_align && mode_r[0].update_select && evt[0].half_evt && pend_r[0] && !upd_wr[0])
    |=> !pend_r[0] && act_duty_r[0] == $past(buf_duty_r[0]) && act_pol_r[0] == $past(buf_pol_r[0]))
    else $error("half period update not applied");

  dis_level_a: assert property (@(posedge CORE_CLK) disable iff (RESET)
    (!ena_r[0] && mode_r[0] == 9'h000) |=> PWM_HIGH[0] == $past(act_pol_r[0]))
    else $error("disabled level does not follow polarity");

  dis_inv_a: assert property (@(posedge CORE_CLK) disable iff (RESET)
    (!ena_r[0] && mode_r[0] == 9'h008) |=> PWM_HIGH[0] == !$past(act_pol_r[0]))
    else $error("disabled level not inverted");

  trig_src_a: assert property (@(posedge CORE_CLK) disable iff (RESET)
    (mode_r[0].timer_trigger_select && ch_evt[0]) |=> TRIG_OUT[0] ##1 (TRIG_OUT[0] == $past(ch_evt[0])))
    else $error("trigger does not follow counter event");

  dt_bypass_a: assert property (@(posedge CORE_CLK) disable iff (RESET)
    (mode_r[0] == 9'h000) |=> (PWM_HIGH[0] == $past(oc[0]) && PWM_LOW[0] == !$past(oc[0])))
    else $error("bypassed dead time altered outputs");

  hs_inv_a: assert property (@(posedge CORE_CLK) disable iff (RESET)
    (mode_r[0].high_side_invert && !mode_r[0].push_pull_enable) |=> PWM_HIGH[0] == !$past(dt_h[0]))
    else $error("high side not inverted");

  ls_inv_a: assert property (@(posedge CORE_CLK) disable iff (RESET)
    (mode_r[0].low_side_invert && !mode_r[0].push_pull_enable) |=> PWM_LOW[0] == !$past(dt_l[0]))
    else $error("low side not inverted");

  pp_gate_a: assert property (@(posedge CORE_CLK) disable iff (RESET)
    (mode_r[0].push_pull_enable && !mode_r[0].high_side_invert && phase_r[0]) |=> !PWM_HIGH[0])
    else $error("push-pull high side active in low phase");

  ch_indep_a: assert property (@(posedge CORE_CLK) disable iff (RESET)
    (wr && hit(PADDR, 0, `OFS_MODE)) |=> $stable(mode_r[1]))
    else $error("channel 0 write changed channel 1 mode");

endmodule

//--- verif/pwm_switch_stage.sv
// Behavioural half-bridge stages driven by the channel high and low outputs.
// Assumes both side inputs are levels sampled on the core clock.
`timescale 1ns/1ps
`include "pwm_defines.svh"

module pwm_switch_stage (
  // Clock
  input wire logic clk,
  // Gate drives
  input wire logic [`NUM_CH-1:0] high,
  input wire logic [`NUM_CH-1:0] low,
  // Switch node and overlap count
  output logic [`NUM_CH-1:0] phase,
  output int shoot
);
  initial begin
    phase = '0;
    shoot = 0;
  end

  // Both gates off floats the node, so show a changing level, not the last one
  always @(posedge clk) begin
    for (int c = 0; c < `NUM_CH; c++) begin
      if (high[c] === 1'b1 && low[c] === 1'b1) begin
        shoot <= shoot + 1;
      end
      phase[c] <= (high[c] === 1'b1) ? 1'b1 : (low[c] === 1'b1) ? 1'b0 : ~phase[c];
    end
  end
endmodule

//--- verif/pwm_channel_mode_options_bench.sv
// Self-checking bench for the PWM channel mode options behind APB.
// Assumes an APB slave on the bench clock and channel 0 stimulus shows at the pins.
`timescale 1ns/1ps
`include "pwm_defines.svh"

module pwm_channel_mode_options_bench;
  logic clk, rst, psel, pen, pwr, pready, pslverr, irq, tprev;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, r;
  logic [`NUM_CH-1:0] ph, pl, tr, phase;
  int shoot, mismatches, checks, cyc, since, w, iv, iv0, wh0, wl0, wh1, wl1, d, p, t0, s0;
  int model[int];
  logic e;

  pwm_mode_top dut(.CORE_CLK(clk), .RESET(rst), .PSEL(psel), .PENABLE(pen), .PWRITE(pwr), .PADDR(paddr),
    .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .PWM_HIGH(ph), .PWM_LOW(pl),
    .TRIG_OUT(tr), .IRQ(irq));
  pwm_switch_stage sw(.clk(clk), .high(ph), .low(pl), .phase(phase), .shoot(shoot));

  initial begin
    clk = 0;
    forever #2.5 clk = ~clk;
  end

  // Cycles since the last channel 0 trigger rise
  always @(posedge clk) begin
    cyc <= cyc + 1;
    since <= (tr[0] === 1'b1 && tprev !== 1'b1) ? 0 : since + 1;
    tprev <= tr[0];
  end

  task results;
    $display("mismatches %0d checks %0d", mismatches, checks);
    if (mismatches == 0 && checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("Error at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask

  task apb(input logic wr, input logic [7:0] a, input logic [31:0] dt, output logic [31:0] rd, output logic er);
    @(posedge clk);
    psel <= 1;
    pen <= 0;
    pwr <= wr;
    paddr <= a;
    pwdata <= dt;
    @(posedge clk);
    pen <= 1;
    // Waits for the slave however long it takes; only the watchdog ends a hang
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 0;
    pen <= 0;
  endtask

  function int msk(input logic [7:0] a);
    case (a[3:2])
      0: return 32'h000001FF;
      2: return 32'h0001FFFF;
      default: return 32'h0000FFFF;
    endcase
  endfunction

  task wr(input logic [7:0] a, input int dt);
    logic [31:0] x;
    logic y;
    apb(1, a, dt, x, y);
    if (a < 8'h40) model[a] = dt & msk(a);
  endtask

  task rd(input logic [7:0] a, output logic [31:0] x);
    logic y;
    apb(0, a, 0, x, y);
  endtask

  task rdc(input logic [7:0] a);
    logic [31:0] x;
    rd(a, x);
    chk(x, model[a]);
  endtask

  function logic sig(input int c, input int s);
    return s == 0 ? ph[c] : s == 1 ? pl[c] : tr[c];
  endfunction

  // Width of the next high pulse and the rise-to-rise interval
  task meas(input int c, input int s, output int wd, output int it);
    logic q;
    int n;
    // Falling edge sampling keeps clear of the edge that launches the outputs
    q = sig(c, s);
    n = 0;
    wd = 0;
    it = 0;
    while (n < 3000) begin
      @(negedge clk);
      n++;
      if (sig(c, s) === 1'b1 && q !== 1'b1) break;
      q = sig(c, s);
    end
    while (n < 3000 && sig(c, s) === 1'b1) begin
      @(negedge clk);
      n++;
      wd++;
      it++;
    end
    while (n < 3000 && sig(c, s) !== 1'b1) begin
      @(negedge clk);
      n++;
      it++;
    end
    if (n >= 3000) chk(0, 1);
  endtask

  initial begin
    #300000;
    mismatches++;
    results;
  end

  initial begin
    rst = 1;
    psel = 0;
    pen = 0;
    pwr = 0;
    paddr = 0;
    pwdata = 0;
    void'($urandom(32'h3636));
    for (int a = 0; a < 64; a += 4) model[a] = 0;
    for (int c = 0; c < 2; c++) begin
      model[c*32] = 0;
      model[c*32+4] = `PERIOD_RST;
      model[c*32+8] = `DUTY_RST;
      model[c*32+12] = `DT_RST;
    end
    repeat (3) @(posedge clk);
    rst <= 0;
    for (int a = 0; a < 64; a += 4) rdc(8'(a));
    apb(0, 8'h40, 0, r, e);
    chk(e, 1);
    chk(r, 0);
    apb(1, 8'h44, 32'hFFFF, r, e);
    chk(e, 1);
    wr(8'h20, -1);
    rdc(8'h20);
    wr(8'h20, 0);
    for (int k = 0; k < 8; k++) begin
      wr(`OFS_MODE, k[0] << 3 | k[1] << 6 | k[2] << 7);
      repeat (4) @(posedge clk);
      chk({tr[0], ph[0], pl[0]}, {k[0], k[0] ^ k[1], !k[0] ^ k[2]});
      chk({tr[1], ph[1], pl[1]}, 3'b001);
      if (ph[0] ^ pl[0]) chk(phase[0], ph[0]);
    end
    wr(`OFS_PERIOD, 9);
    for (int k = 0; k < 4; k++) begin
      wr(`OFS_MODE, k[0] | k[1] << 1 | 16'h10);
      wr(`OFS_ENA, 1);
      meas(0, 2, w, iv);
      meas(0, 2, w, iv);
      chk(w, 1);
      chk(iv, !k[0] ? 10 : k[1] ? 9 : 18);
      wr(`OFS_ENA, 0);
    end
    wr(`OFS_ENA, 1);
    repeat (30) @(posedge clk);
    rd(`OFS_ISR, r);
    chk({r[0], irq}, 2'b10);
    wr(`OFS_IMR, 1);
    repeat (3) @(posedge clk);
    chk(irq, 1);
    wr(`OFS_ENA, 0);
    repeat (30) @(posedge clk);
    wr(`OFS_ISR, 1);
    repeat (3) @(posedge clk);
    rd(`OFS_ISR, r);
    chk({r[0], irq}, 2'b00);
    wr(`OFS_PERIOD, 19);
    for (int k = 0; k < 4; k++) begin
      wr(`OFS_MODE, k[0] | k[1] << 2 | 16'h10);
      wr(`OFS_ENA, 1);
      meas(0, 2, w, iv);
      repeat (2) begin
        d = $urandom_range(18, 1);
        p = $urandom_range(1, 0);
        repeat ($urandom_range(40, 0)) @(posedge clk);
        wr(`OFS_UPDATE, d | p << 16);
        t0 = cyc;
        do rd(`OFS_STAT, r); while (r[0] !== 1'b0 && cyc - t0 < 200);
        chk(cyc - t0 <= (k == 3 ? 27 : k[0] ? 46 : 28), 1);
        chk(since <= 6 || (k == 3 && since >= 15 && since <= 25), 1);
        chk(r[8], p);
        rdc(`OFS_UPDATE);
      end
      wr(`OFS_ENA, 0);
    end
    wr(`OFS_MODE, 0);
    wr(`OFS_UPDATE, 8);
    wr(`OFS_DEADTIME, 3 | 5 << 8);
    wr(`OFS_ENA, 1);
    repeat (50) @(posedge clk);
    meas(0, 0, wh0, iv0);
    meas(0, 1, wl0, iv);
    chk(wh0, 12);
    chk(wl0, 8);
    chk(iv0, 20);
    wr(`OFS_MODE, 16'h20);
    repeat (5) @(posedge clk);
    s0 = shoot;
    meas(0, 0, wh1, iv);
    meas(0, 1, wl1, iv);
    chk(wh0 - wh1, 4);
    chk(wl0 - wl1, 6);
    chk(shoot - s0, 0);
    wr(`OFS_MODE, 16'h100);
    repeat (5) @(posedge clk);
    meas(0, 0, w, iv);
    meas(0, 0, w, iv);
    chk(iv, 40);
    results;
  end
endmodule
